// *** verilog/port_pins.sv ***
// pin control for ports 0, 1 and 2
// Summary of operation
// - port 0 is eight bidirectional pins, each driven from its stored latch.
// - each port 0 pin direction comes from its port 0 direction bit.
// - every port 0 pin has a software switchable pull-up.
// - buffer nibbles move to port 0 low/high pins on trigger, 4 or 8 bits.
// - real-time control enables buffer-to-latch nibble transfers and picks their trigger.
// - reset makes port 0 all inputs; latch contents are not cleared.
// - port 1 is eight bidirectional pins, per-pin direction and pull-ups.
// - port 1 pin 2 serves serial channel 2 clock when its select bit is set.
// - port 1 pin 3 feeds serial channel 2 receive data when selected.
// - port 1 pin 4 is driven by serial channel 2 transmit data when selected.
// - pins 2-4 are plain port pins when unselected; others always are.
// - reset makes port 1 all inputs; latch contents are not cleared.
// - port 2 is eight input pins also feeding control inputs; pin 5 can also output.
// - only port 2 pins 2-7 have switchable pull-ups.
// - port 2 pin 5 drives serial 1 clock when its mode enables it.
// - port 2 pin 1 feeds irq 0, timer 1 capture and clock, rt trigger.
// - port 2 pin 4 feeds irq 3, timer 0 capture and count clock.
// - port 2 pin 5 feeds irq 4, uart 0 baud clock, serial 1 clock.
// - port 2 pin 6 feeds irq 5 and the converter start trigger.
// - port 2 reads return the pin level two clocks late; reset clears them to 0.
// - the nmi pin is accepted whatever the interrupt enable state.
// - software picks rising or falling edge detection for the nmi pin.
module port_pins (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire port_pkg::cfg_sel_t cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic rt_trig_low,
  input wire logic rt_trig_high,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  output logic [7:0] p0_pullup_en,
  output logic [7:0] p0_read,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p1_pullup_en,
  output logic [7:0] p1_read,
  input wire logic sync2_clock_out,
  input wire logic sync2_clock_oe,
  input wire logic uart2_transmit_out,
  output logic sync2_serial_clock,
  output logic uart2_receive_in,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_pullup_en,
  output logic [7:0] p2_read,
  output logic p2_5_out,
  output logic p2_5_oe,
  input wire logic sync1_clock_out,
  output logic nmi_req,
  output logic [5:0] ext_irq_in,
  output logic timer1_capture_trig,
  output logic timer1_count_clock,
  output logic rt_ext_trig,
  output logic timer2_capture_trig,
  output logic timer2_ext_clock_in,
  output logic timer0_capture_trig,
  output logic timer0_count_clock,
  output logic uart0_baud_clock_in,
  output logic sync1_serial_clock,
  output logic adc_ext_trig,
  output logic sync0_data_in
);
  import port_pkg::*;

  typedef struct packed {
    logic [7:0] latch0;
    logic [7:0] dir0;
    logic [7:0] pu0;
    logic [3:0] rt_buffer_low;
    logic [3:0] rt_buffer_high;
    logic [3:0] rt_ctrl;
    logic [7:0] latch1;
    logic [7:0] dir1;
    logic [7:0] pu1;
    logic [7:0] fsel1;
    logic [5:0] pu2;
    logic [7:0] edge0;
    logic [7:0] sync1_mode;
    logic nmi_prev;
    logic irq0_prev;
    logic nmi_pulse;
  } port_state_t;

  port_state_t q;
  port_state_t d;
  logic [7:0] p2s;
  logic ext_edge;
  logic trig_lo;
  logic trig_hi;

  port2_sync_if sif ();

  assign sif.raw = p2_in;
  assign p2s = sif.synced;

  port2_sync port2_sync_inst (
    .clk(clk),
    .rst(rst),
    .sif(sif)
  );

  // real-time trigger selection
  always_comb
  begin
    ext_edge = p2s[P2_IRQ0_BIT] & ~q.irq0_prev;
    trig_lo = q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EXT_TRIG] ? ext_edge : rt_trig_low;
    trig_hi = q.rt_ctrl[RT_OUTPUT_CONTROL_REG_MODE8] ? trig_lo :
      (q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EXT_TRIG] ? ext_edge : rt_trig_high);
  end

  always_comb
  begin
    d = q;
    if (cfg_wr)
    begin
      case (cfg_addr)
        CFG_LATCH0: d.latch0 = cfg_wdata;
        CFG_DIR0: d.dir0 = cfg_wdata;
        CFG_PU0: d.pu0 = cfg_wdata;
        CFG_RT_LOW: d.rt_buffer_low = cfg_wdata[3:0];
        CFG_RT_HIGH: d.rt_buffer_high = cfg_wdata[3:0];
        CFG_RT_CTRL: d.rt_ctrl = cfg_wdata[3:0];
        CFG_LATCH1: d.latch1 = cfg_wdata;
        CFG_DIR1: d.dir1 = cfg_wdata;
        CFG_PU1: d.pu1 = cfg_wdata;
        CFG_FSEL1: d.fsel1 = cfg_wdata;
        CFG_PU2: d.pu2 = cfg_wdata[7:2];
        CFG_EDGE0: d.edge0 = cfg_wdata;
        CFG_SYNC1_MODE: d.sync1_mode = cfg_wdata;
        default: d = q;
      endcase
    end
    // timed transfer wins over a software latch write
    if (q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_LOW] && trig_lo)
    begin
      d.latch0[3:0] = q.rt_buffer_low;
    end
    if (q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_HIGH] && trig_hi)
    begin
      d.latch0[7:4] = q.rt_buffer_high;
    end
    d.nmi_prev = p2s[P2_NMI_BIT];
    d.irq0_prev = p2s[P2_IRQ0_BIT];
    // nmi edge, never gated by any interrupt enable
    d.nmi_pulse = q.edge0[EDGE_NMI_RISE] ? (p2s[P2_NMI_BIT] & ~q.nmi_prev) :
      (~p2s[P2_NMI_BIT] & q.nmi_prev);
  end

  // latches keep their contents through reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q.dir0 <= DIR_RST;
      q.pu0 <= PU_RST;
      q.rt_buffer_low <= RT_BUF_RST;
      q.rt_buffer_high <= RT_BUF_RST;
      q.rt_ctrl <= RT_OUTPUT_CONTROL_REG_RST;
      q.dir1 <= DIR_RST;
      q.pu1 <= PU_RST;
      q.fsel1 <= FSEL_RST;
      q.pu2 <= PU2_RST;
      q.edge0 <= EDGE_RST;
      q.sync1_mode <= SYNC1_MODE_RST;
      q.nmi_prev <= 1'b0;
      q.irq0_prev <= 1'b0;
      q.nmi_pulse <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // port 0 pins
  assign p0_out = q.latch0;
  assign p0_oe = ~q.dir0;
  assign p0_pullup_en = q.pu0 & q.dir0;
  assign p0_read = (q.latch0 & ~q.dir0) | (p0_in & q.dir0);

  // port 1 pins with serial channel 2 alternates
  always_comb
  begin
    p1_out = q.latch1;
    p1_oe = ~q.dir1;
    if (q.fsel1[P1_SYNC2_SERIAL_CLOCK_BIT])
    begin
      p1_out[P1_SYNC2_SERIAL_CLOCK_BIT] = sync2_clock_out;
      p1_oe[P1_SYNC2_SERIAL_CLOCK_BIT] = sync2_clock_oe;
    end
    if (q.fsel1[P1_UART2_RECEIVE_IN_BIT])
    begin
      p1_oe[P1_UART2_RECEIVE_IN_BIT] = 1'b0;
    end
    if (q.fsel1[P1_UART2_TRANSMIT_OUT_BIT])
    begin
      p1_out[P1_UART2_TRANSMIT_OUT_BIT] = uart2_transmit_out;
      p1_oe[P1_UART2_TRANSMIT_OUT_BIT] = 1'b1;
    end
  end

  assign p1_pullup_en = q.pu1 & ~p1_oe;
  assign p1_read = (q.latch1 & ~q.dir1) | (p1_in & q.dir1);
  assign sync2_serial_clock = q.fsel1[P1_SYNC2_SERIAL_CLOCK_BIT] & p1_in[P1_SYNC2_SERIAL_CLOCK_BIT];
  assign uart2_receive_in = ~q.fsel1[P1_UART2_RECEIVE_IN_BIT] | p1_in[P1_UART2_RECEIVE_IN_BIT];

  // port 2 pins and their consumers
  assign p2_pullup_en = {q.pu2, 2'b00};
  assign p2_read = p2s;
  assign p2_5_oe = q.sync1_mode[SYNC1_EN_BIT] &
    (q.sync1_mode[1:0] != SYNC1_CLK_EXT);
  assign p2_5_out = sync1_clock_out;
  assign nmi_req = q.nmi_pulse;
  assign ext_irq_in = p2s[P2_IRQ5_BIT:P2_IRQ0_BIT];
  assign timer1_capture_trig = p2s[P2_IRQ0_BIT];
  assign timer1_count_clock = p2s[P2_IRQ0_BIT];
  assign rt_ext_trig = p2s[P2_IRQ0_BIT];
  assign timer2_capture_trig = p2s[2];
  assign timer2_ext_clock_in = p2s[3];
  assign timer0_capture_trig = p2s[P2_IRQ3_BIT];
  assign timer0_count_clock = p2s[P2_IRQ3_BIT];
  assign uart0_baud_clock_in = p2s[P2_IRQ4_BIT];
  assign sync1_serial_clock = p2_5_oe ? sync1_clock_out : p2s[P2_IRQ4_BIT];
  assign adc_ext_trig = p2s[P2_IRQ5_BIT];
  assign sync0_data_in = p2s[P2_SI0_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_DIR0_WRITE: assert property (
    cfg_wr && cfg_addr == CFG_DIR0 |=> p0_oe == ~$past(cfg_wdata))
    else $error("port 0 enable does not follow direction write");

  AST_DIR1_WRITE: assert property (
    cfg_wr && cfg_addr == CFG_DIR1 && q.fsel1 == 8'h00
    |=> p1_oe == ~$past(cfg_wdata))
    else $error("port 1 enable does not follow direction write");

  AST_RT_LOW: assert property (
    q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_LOW] && !q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EXT_TRIG] && rt_trig_low
    |=> p0_out[3:0] == $past(q.rt_buffer_low))
    else $error("real-time low nibble not transferred");

  AST_RT_MODE8: assert property (
    q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_LOW] && q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_HIGH] && q.rt_ctrl[RT_OUTPUT_CONTROL_REG_MODE8] &&
    !q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EXT_TRIG] && rt_trig_low
    |=> p0_out == {$past(q.rt_buffer_high), $past(q.rt_buffer_low)})
    else $error("8-bit real-time transfer did not move both nibbles");

  AST_RT_EXT: assert property (
    q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_LOW] && q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EXT_TRIG] && $rose(p2s[P2_IRQ0_BIT])
    |=> p0_out[3:0] == $past(q.rt_buffer_low))
    else $error("pin 1 edge did not trigger the real-time transfer");

  AST_RT_OFF: assert property (
    !q.rt_ctrl[RT_OUTPUT_CONTROL_REG_EN_HIGH] && !(cfg_wr && cfg_addr == CFG_LATCH0)
    |=> p0_out[7:4] === $past(p0_out[7:4]))
    else $error("high nibble changed without real-time enable");

  AST_UART2_TRANSMIT_OUT: assert property (
    q.fsel1[P1_UART2_TRANSMIT_OUT_BIT] |-> p1_oe[P1_UART2_TRANSMIT_OUT_BIT] &&
    p1_out[P1_UART2_TRANSMIT_OUT_BIT] == uart2_transmit_out)
    else $error("port 1 pin 4 not driven by transmit data");

  AST_UART2_RECEIVE_IN: assert property (
    q.fsel1[P1_UART2_RECEIVE_IN_BIT] |-> !p1_oe[P1_UART2_RECEIVE_IN_BIT] &&
    uart2_receive_in == p1_in[P1_UART2_RECEIVE_IN_BIT])
    else $error("port 1 pin 3 not routed to receive data");

  AST_PLAIN_P12: assert property (
    !q.fsel1[P1_SYNC2_SERIAL_CLOCK_BIT] |-> p1_oe[P1_SYNC2_SERIAL_CLOCK_BIT] == ~q.dir1[P1_SYNC2_SERIAL_CLOCK_BIT] &&
    p1_out[P1_SYNC2_SERIAL_CLOCK_BIT] === q.latch1[P1_SYNC2_SERIAL_CLOCK_BIT])
    else $error("port 1 pin 2 not a plain port pin");

  AST_P2_PULLUP: assert property (
    p2_pullup_en[1:0] == 2'b00)
    else $error("port 2 pin 0 or 1 has a pull-up");

  AST_P2_PU_WRITE: assert property (
    cfg_wr && cfg_addr == CFG_PU2
    |=> p2_pullup_en[7:P2_PU_LSB] == $past(cfg_wdata[7:P2_PU_LSB]))
    else $error("port 2 pull-ups do not follow the write");

  AST_P2_SYNC: assert property (
    !$past(rst) && !$past(rst, 2) |-> p2_read == $past(p2_in, 2))
    else $error("port 2 read is not the pin two cycles back");

  AST_NMI_RISE: assert property (
    q.edge0[EDGE_NMI_RISE] && p2s[P2_NMI_BIT] && !q.nmi_prev |=> nmi_req ##1 !nmi_req)
    else $error("nmi rising edge not reported as one pulse");

  AST_NMI_FALL: assert property (
    !q.edge0[EDGE_NMI_RISE] && !p2s[P2_NMI_BIT] && q.nmi_prev |=> nmi_req ##1 !nmi_req)
    else $error("nmi falling edge not reported as one pulse");

  AST_RESET_INPUT: assert property (
    $fell(rst) |-> p0_oe == 8'h00 && p1_oe == 8'h00)
    else $error("ports not inputs after reset");

  AST_P25_OUT: assert property (
    q.sync1_mode[SYNC1_EN_BIT] && q.sync1_mode[1:0] != SYNC1_CLK_EXT |-> p2_5_oe &&
    sync1_serial_clock == sync1_clock_out)
    else $error("port 2 pin 5 not driving serial clock");

endmodule : port_pins

// *** verilog/port_pkg.sv ***
// constants and types shared by the port pin control block
package port_pkg;

  // configuration write targets
  typedef enum logic [3:0] {
    CFG_LATCH0 = 4'h0,
    CFG_DIR0 = 4'h1,
    CFG_PU0 = 4'h2,
    CFG_RT_LOW = 4'h3,
    CFG_RT_HIGH = 4'h4,
    CFG_RT_CTRL = 4'h5,
    CFG_LATCH1 = 4'h6,
    CFG_DIR1 = 4'h7,
    CFG_PU1 = 4'h8,
    CFG_FSEL1 = 4'h9,
    CFG_PU2 = 4'ha,
    CFG_EDGE0 = 4'hb,
    CFG_SYNC1_MODE = 4'hc
  } cfg_sel_t;

  // values after reset; direction bit 1 means input
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [3:0] RT_OUTPUT_CONTROL_REG_RST = 4'h0;
  localparam logic [3:0] RT_BUF_RST = 4'h0;
  localparam logic [5:0] PU2_RST = 6'h00;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] SYNC1_MODE_RST = 8'h00;

  // real-time output control fields
  localparam int RT_OUTPUT_CONTROL_REG_EN_LOW = 0;
  localparam int RT_OUTPUT_CONTROL_REG_EN_HIGH = 1;
  localparam int RT_OUTPUT_CONTROL_REG_MODE8 = 2;
  localparam int RT_OUTPUT_CONTROL_REG_EXT_TRIG = 3;

  // port 1 alternate pins
  localparam int P1_SYNC2_SERIAL_CLOCK_BIT = 2;
  localparam int P1_UART2_RECEIVE_IN_BIT = 3;
  localparam int P1_UART2_TRANSMIT_OUT_BIT = 4;

  // port 2 pins
  localparam int P2_NMI_BIT = 0;
  localparam int P2_IRQ0_BIT = 1;
  localparam int P2_PU_LSB = 2;
  localparam int P2_IRQ3_BIT = 4;
  localparam int P2_IRQ4_BIT = 5;
  localparam int P2_IRQ5_BIT = 6;
  localparam int P2_SI0_BIT = 7;

  // edge register: bit 0 high selects rising edge on the nmi pin
  localparam int EDGE_NMI_RISE = 0;

  // sync serial 1 mode: enable bit and clock select field
  localparam int SYNC1_EN_BIT = 7;
  localparam logic [1:0] SYNC1_CLK_EXT = 2'b00;

endpackage : port_pkg

// *** verilog/port2_sync_if.sv ***
// carries port 2 raw pin levels and their synchronised copies
interface port2_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : port2_sync_if

// *** verilog/port2_sync.sv ***
// two-stage synchroniser for the port 2 inputs
module port2_sync (
  input wire logic clk,
  input wire logic rst,
  port2_sync_if.sync_side sif
);
  import port_pkg::*;

  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb
  begin
    d.stage1 = sif.raw;
    d.stage2 = q.stage1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sif.synced = q.stage2;

endmodule : port2_sync

// *** verif/board_model.sv ***
// board side of ports 0 and 1: resolves pin levels
module board_model (
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] ext0,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] ext1,
  output logic [7:0] p0_in,
  output logic [7:0] p1_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven bits follow the device, the rest the board
  assign p0_in = (p0_out & p0_oe) | (ext0 & ~p0_oe);
  assign p1_in = (p1_out & p1_oe) | (ext1 & ~p1_oe);
endmodule : board_model

// *** verif/port_pins_bench.sv ***
// self-checking bench for the port pin control block
module port_pins_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import port_pkg::*;
  logic clk, rst, cfg_wr, rt_trig_low, rt_trig_high;
  cfg_sel_t cfg_addr;
  logic [7:0] cfg_wdata, p0_in, p0_out, p0_oe, p0_pullup_en, p0_read, ext0, ext1;
  logic [7:0] p1_in, p1_out, p1_oe, p1_pullup_en, p1_read, p2_in, p2_pullup_en, p2_read;
  logic sync2_clock_out, sync2_clock_oe, uart2_transmit_out, sync2_serial_clock;
  logic uart2_receive_in, p2_5_out, p2_5_oe, sync1_clock_out, nmi_req;
  logic [5:0] ext_irq_in;
  logic timer1_capture_trig, timer1_count_clock, rt_ext_trig, timer2_capture_trig;
  logic timer2_ext_clock_in, timer0_capture_trig, timer0_count_clock;
  logic uart0_baud_clock_in, sync1_serial_clock, adc_ext_trig, sync0_data_in;
  int fails, num_checks, cycles;

  port_pins port_pins_inst (.clk, .rst, .cfg_wr, .cfg_addr, .cfg_wdata, .rt_trig_low,
    .rt_trig_high, .p0_in, .p0_out, .p0_oe, .p0_pullup_en, .p0_read, .p1_in, .p1_out,
    .p1_oe, .p1_pullup_en, .p1_read, .sync2_clock_out, .sync2_clock_oe,
    .uart2_transmit_out, .sync2_serial_clock, .uart2_receive_in, .p2_in, .p2_pullup_en,
    .p2_read, .p2_5_out, .p2_5_oe, .sync1_clock_out, .nmi_req, .ext_irq_in,
    .timer1_capture_trig, .timer1_count_clock, .rt_ext_trig, .timer2_capture_trig,
    .timer2_ext_clock_in, .timer0_capture_trig, .timer0_count_clock,
    .uart0_baud_clock_in, .sync1_serial_clock, .adc_ext_trig, .sync0_data_in);
  board_model board_model_inst (.p0_out, .p0_oe, .ext0, .p1_out, .p1_oe, .ext1,
    .p0_in, .p1_in);

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  task automatic wr(input cfg_sel_t a, input logic [7:0] d);
    tick(1);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr = 1'b0;
  endtask : wr

  task automatic trig(input logic lo, input logic hi);
    tick(1);
    rt_trig_low = lo;
    rt_trig_high = hi;
    tick(1);
    rt_trig_low = 1'b0;
    rt_trig_high = 1'b0;
  endtask : trig

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic nmi_edge(input logic v, input logic [7:0] e);
    p2_in[0] = v;
    tick(2);
    chk("nmi_req", 8'h00, nmi_req);
    tick(1);
    chk("nmi_req", e, nmi_req);
    tick(1);
    chk("nmi_req", 8'h00, nmi_req);
  endtask : nmi_edge

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    {cfg_wr, rt_trig_low, rt_trig_high, sync2_clock_out, sync2_clock_oe} = '0;
    {uart2_transmit_out, sync1_clock_out} = '0;
    cfg_addr = CFG_LATCH0;
    cfg_wdata = 8'h00;
    {ext0, ext1, p2_in} = '0;
    rst = 1'b1;
    tick(5);
    chk("p0_oe", 8'h00, p0_oe);
    chk("p1_oe", 8'h00, p1_oe);
    chk("pullups", 8'h00, p0_pullup_en | p1_pullup_en | p2_pullup_en);
    rst = 1'b0;
    wr(CFG_LATCH0, 8'ha5);
    chk("p0_oe", 8'h00, p0_oe);
    ext0 = 8'h3c;
    wr(CFG_DIR0, 8'h0f);
    chk("p0_oe", 8'hf0, p0_oe);
    wr(CFG_PU0, 8'hff);
    chk("p0_pullup_en", 8'h0f, p0_pullup_en);
    chk("p0_read", 8'hac, p0_read);
    wr(CFG_RT_LOW, 8'h03);
    wr(CFG_RT_HIGH, 8'h0c);
    trig(1'b1, 1'b1);
    chk("p0_out", 8'ha5, p0_out);
    wr(CFG_RT_CTRL, 8'h01);
    trig(1'b0, 1'b1);
    chk("p0_out", 8'ha5, p0_out);
    trig(1'b1, 1'b0);
    chk("p0_out", 8'ha3, p0_out);
    wr(CFG_RT_CTRL, 8'h02);
    trig(1'b1, 1'b1);
    chk("p0_out", 8'hc3, p0_out);
    wr(CFG_RT_CTRL, 8'h07);
    wr(CFG_RT_LOW, 8'h09);
    trig(1'b1, 1'b0);
    chk("p0_out", 8'hc9, p0_out);
    wr(CFG_RT_CTRL, 8'h09);
    wr(CFG_RT_LOW, 8'h05);
    p2_in[1] = 1'b1;
    tick(6);
    chk("p0_out", 8'hc5, p0_out);
    wr(CFG_LATCH1, 8'hff);
    wr(CFG_DIR1, 8'h00);
    chk("p1_read", 8'hff, p1_read);
    ext1 = 8'h04;
    wr(CFG_FSEL1, 8'h1c);
    chk("p1_oe", 8'hf3, p1_oe);
    chk("p1_out", 8'heb, p1_out);
    chk("sync2_serial_clock", 8'h01, sync2_serial_clock);
    chk("uart2_receive_in", 8'h00, uart2_receive_in);
    wr(CFG_PU1, 8'hff);
    chk("p1_pullup_en", 8'h0c, p1_pullup_en);
    {sync2_clock_oe, sync2_clock_out, uart2_transmit_out} = 3'b111;
    #1;
    chk("p1_oe", 8'hf7, p1_oe);
    chk("p1_out", 8'hff, p1_out);
    wr(CFG_FSEL1, 8'h00);
    chk("p1_oe", 8'hff, p1_oe);
    chk("uart2_receive_in", 8'h01, uart2_receive_in);
    chk("sync2_serial_clock", 8'h00, sync2_serial_clock);
    wr(CFG_PU2, 8'hff);
    chk("p2_pullup_en", 8'hfc, p2_pullup_en);
    p2_in = 8'hd6;
    tick(1);
    chk("p2_read", 8'h02, p2_read);
    tick(1);
    chk("p2_read", 8'hd6, p2_read);
    chk("ext_irq_in", 8'h2b, ext_irq_in);
    chk("alt_a", 8'hfb, {timer1_capture_trig, timer1_count_clock, rt_ext_trig,
      timer0_capture_trig, timer0_count_clock, uart0_baud_clock_in, adc_ext_trig,
      sync0_data_in});
    chk("alt_b", 8'h04, {timer2_capture_trig, timer2_ext_clock_in,
      sync1_serial_clock});
    sync1_clock_out = 1'b1;
    wr(CFG_SYNC1_MODE, 8'h81);
    chk("p2_5", 8'h07, {p2_5_oe, p2_5_out, sync1_serial_clock});
    chk("p2_read", 8'hd6, p2_read);
    wr(CFG_SYNC1_MODE, 8'h80);
    chk("p2_5_oe", 8'h00, p2_5_oe);
    wr(CFG_EDGE0, 8'h01);
    nmi_edge(1'b1, 8'h01);
    nmi_edge(1'b0, 8'h00);
    wr(CFG_EDGE0, 8'h00);
    nmi_edge(1'b1, 8'h00);
    nmi_edge(1'b0, 8'h01);
    rst = 1'b1;
    tick(1);
    chk("p0_oe", 8'h00, p0_oe | p1_oe);
    chk("p0_out", 8'hc5, p0_out);
    chk("p2_read", 8'h00, p2_read);
    rst = 1'b0;
    tick(1);
    chk("p2_read", 8'h00, p2_read);
    chk("nmi_req", 8'h00, nmi_req);
    tick(1);
    chk("p2_read", 8'hd6, p2_read);
    chk("p0_oe", 8'h00, p0_oe | p1_oe);
    tick(2);
    summarize();
  end
endmodule : port_pins_bench
